// ### ppm_cnt_if.sv
// Control and count signals between the mode controller and a prescaler counter
`timescale 1ns/1ns
interface ppm_cnt_if #(parameter int WIDTH = 13);
  logic clr;
  logic adv;
  logic [WIDTH-1:0] count;
  modport ctl (output clr, output adv, input count);
  modport cnt (input clr, input adv, output count);
endinterface : ppm_cnt_if

// ### ppm_counter.sv
// Free-running prescaler up-counter with synchronous clear
`timescale 1ns/1ns
module ppm_counter (
  input wire logic clk,
  input wire logic rst_n,
  ppm_cnt_if.cnt bus
);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus.count <= '0;
    end else if (bus.clr) begin
      bus.count <= '0;
    end else if (bus.adv) begin
      bus.count <= bus.count + 1'b1;
    end
  end
endmodule : ppm_counter

// ### ppm_periph_model.sv
// Peripheral-side model: subclock source and tap consumers
`timescale 1ns/1ns
module ppm_periph_model #(parameter int SUB_PER = 8) (
  input wire logic clk,
  input wire logic clr,
  input wire logic [3:0] sys_sel,
  input wire logic [ppm_pkg::SYS_PS_W-1:0] sysclk_taps,
  input wire logic [ppm_pkg::SUB_PS_W-1:0] subclk_taps,
  input wire logic timekeeper_tick,
  output logic subclk_tick,
  output int n_sys,
  output int n_sub,
  output int n_tk
);
  import ppm_pkg::*;
  int ph = 0;
  initial subclk_tick = 1'b0;
  // Subclock period shortened so the run stays brief; it never stops
  always @(posedge clk) begin
    ph <= (ph >= SUB_PER - 1) ? 0 : ph + 1;
    subclk_tick <= (ph == 0);
    if (clr) begin
      n_sys <= 0;
      n_sub <= 0;
      n_tk <= 0;
    end else begin
      n_sys <= n_sys + sysclk_taps[sys_sel];
      n_sub <= n_sub + subclk_taps[0];
      n_tk <= n_tk + timekeeper_tick;
    end
  end
endmodule : ppm_periph_model

// ### ppm_pkg.sv
// Shared constants, register map and mode encoding for the prescaler and power-mode block
package ppm_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SYS_PS_W = 13;
  localparam int SUB_PS_W = 5;
  localparam int SUB_DIV_W = 2;
  localparam int MED_DIV_W = 6;
  localparam int TK_SEL_W = 3;

  localparam logic [ADDR_W-1:0] REG_PCR1 = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PCR2 = 4'h1;
  localparam logic [ADDR_W-1:0] REG_TKMR = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h3;

  localparam logic [DATA_W-1:0] PCR1_RST = 8'h07;
  localparam logic [DATA_W-1:0] PCR1_WMASK = 8'hFB;
  localparam logic [DATA_W-1:0] PCR1_FIXED = 8'h04;
  localparam logic [DATA_W-1:0] PCR2_RST = 8'h00;
  localparam logic [DATA_W-1:0] PCR2_WMASK = 8'h0C;
  localparam logic [DATA_W-1:0] TKMR_RST = 8'h00;
  localparam logic [DATA_W-1:0] TKMR_WMASK = 8'h0F;

  localparam int PCR1_SOFTWARE_STANDBY = 7;
  localparam int PCR1_LOW_SPEED_ON = 3;
  localparam int PCR1_MA_HI = 1;
  localparam int PCR1_MA_LO = 0;
  localparam int PCR2_DIRECT_TRANSFER_ON = 3;
  localparam int PCR2_MEDIUM_SPEED_ON = 2;
  localparam int TKMR_CS3 = 3;
  localparam int TKMR_CS2 = 2;
  localparam int TKMR_SEL_HI = 2;

  localparam logic [SUB_DIV_W-1:0] SUB_DIV_LAST = 2'h3;
  localparam logic [MED_DIV_W-1:0] MED_MASK_ALL = 6'h3F;
  localparam logic [1:0] MED_SHIFT_MAX = 2'h3;
  localparam logic [TK_SEL_W-1:0] SUB_TAP_LAST = 3'h4;
  localparam logic [3:0] SYS_TAP_BASE = 4'h5;

  typedef enum logic [7:0] {
    MODE_ACT_HI = 8'h01,
    MODE_ACT_MED = 8'h02,
    MODE_SLP_HI = 8'h04,
    MODE_SLP_MED = 8'h08,
    MODE_SUBACT = 8'h10,
    MODE_SUBSLP = 8'h20,
    MODE_WATCH = 8'h40,
    MODE_STBY = 8'h80
  } ppm_mode_t;
endpackage : ppm_pkg

// ### ppm_top.sv
// Prescalers, medium-speed divider and operating-mode controller
// Overview of operation
// - system prescaler is 13-bit, counts each clock
// - reset clears system prescaler, then counts
// - standby, watch and subclock modes stop and clear system prescaler
// - system prescaler count is not software visible
// - shared taps, each peripheral picks its own
// - medium mode feeds prescaler clock/64,32,16,8
// - subclock prescaler 5-bit, fed subclock/4
// - reset clears subclock prescaler, then counts
// - subclock prescaler runs in all low-power modes
// - writing both upper select bits clears it
// - subclock taps can drive the timekeeper
// - eight modes, all but high-speed reduce power
// - high-speed active runs everything undivided
// - sleep halts processor, peripherals bar PWM run
// - subactive runs processor and timebase on subclock
// - watch and subsleep keep only the timebase
// - standby halts processor and all peripherals
// - transitions a..j decoded from five bits
// - standby bit picks sleep versus standby or watch
// - only an accepted interrupt wakes a halted mode
// - first power control register resets to 07
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ns
module ppm_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ppm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ppm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ppm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic subclk_tick,
  input wire logic pd_instr,
  input wire logic irq_accepted,
  output ppm_pkg::ppm_mode_t mode,
  output logic sys_osc_run,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic pwm_clk_en,
  output logic [ppm_pkg::SYS_PS_W-1:0] sysclk_taps,
  output logic [ppm_pkg::SUB_PS_W-1:0] subclk_taps,
  output logic timekeeper_tick
);
  import ppm_pkg::*;

  // Tap k fires once per 2**(k+1) advances, on the rise of count bit k
  function automatic logic tap_fire(
    input logic [SYS_PS_W-1:0] c,
    input logic adv,
    input int k
  );
    logic [SYS_PS_W-1:0] low;
    low = (SYS_PS_W'(1) << k) - SYS_PS_W'(1);
    return adv && ((c & low) == low) && !c[k];
  endfunction : tap_fire

  // Transition target for the five control bits, taken at power-down entry
  function automatic ppm_mode_t decode_target(
    input ppm_mode_t cur,
    input logic low_speed_on,
    input logic medium_speed_on,
    input logic software_standby,
    input logic cs3,
    input logic direct_transfer_on
  );
    ppm_mode_t tgt;
    logic in_act;
    logic in_sub;
    tgt = cur;
    in_act = (cur == MODE_ACT_HI) || (cur == MODE_ACT_MED);
    in_sub = (cur == MODE_SUBACT);
    if (!direct_transfer_on) begin
      if (in_act && !low_speed_on && !software_standby) begin
        tgt = medium_speed_on ? MODE_SLP_MED : MODE_SLP_HI;
      end else if ((in_act || in_sub) && low_speed_on && !software_standby && cs3) begin
        tgt = MODE_SUBSLP;
      end else if (in_act && !low_speed_on && software_standby && !cs3) begin
        tgt = MODE_STBY;
      end else if ((in_act || in_sub) && software_standby && cs3) begin
        tgt = MODE_WATCH;
      end
    end else begin
      if (in_act && !low_speed_on && !software_standby) begin
        tgt = medium_speed_on ? MODE_ACT_MED : MODE_ACT_HI;
      end else if (in_sub && !low_speed_on && software_standby && cs3) begin
        tgt = medium_speed_on ? MODE_ACT_MED : MODE_ACT_HI;
      end else if (in_act && low_speed_on && software_standby && cs3) begin
        tgt = MODE_SUBACT;
      end
    end
    return tgt;
  endfunction : decode_target

  // Software registers
  logic [DATA_W-1:0] pcr1;
  logic [DATA_W-1:0] pcr2;
  logic [DATA_W-1:0] tkmr;
  logic [DATA_W-1:0] next_rdata;

  // Divider state and mode
  logic [MED_DIV_W-1:0] med_cnt;
  logic [SUB_DIV_W-1:0] sub_div;
  ppm_mode_t next_mode;

  ppm_cnt_if #(.WIDTH(SYS_PS_W)) sys_bus ();
  ppm_cnt_if #(.WIDTH(SUB_PS_W)) sub_bus ();

  // Control bit views
  wire logic low_speed_on = pcr1[PCR1_LOW_SPEED_ON];
  wire logic software_standby = pcr1[PCR1_SOFTWARE_STANDBY];
  wire logic [1:0] med_sel = {pcr1[PCR1_MA_HI], pcr1[PCR1_MA_LO]};
  wire logic medium_speed_on = pcr2[PCR2_MEDIUM_SPEED_ON];
  wire logic direct_transfer_on = pcr2[PCR2_DIRECT_TRANSFER_ON];
  wire logic cs3 = tkmr[TKMR_CS3];
  wire logic [TK_SEL_W-1:0] tk_sel = tkmr[TKMR_SEL_HI:0];

  // Bus decode
  wire logic wr_pcr1 = reg_wr && (reg_addr == REG_PCR1);
  wire logic wr_pcr2 = reg_wr && (reg_addr == REG_PCR2);
  wire logic wr_tkmr = reg_wr && (reg_addr == REG_TKMR);
  wire logic sub_clr_req = wr_tkmr && reg_wdata[TKMR_CS3] && reg_wdata[TKMR_CS2];

  // Mode classes
  wire logic is_act_hi = (mode == MODE_ACT_HI);
  wire logic is_act_med = (mode == MODE_ACT_MED);
  wire logic is_slp_hi = (mode == MODE_SLP_HI);
  wire logic is_slp_med = (mode == MODE_SLP_MED);
  wire logic is_subact = (mode == MODE_SUBACT);
  wire logic is_medium = is_act_med || is_slp_med;
  wire logic is_active = is_act_hi || is_act_med;
  wire logic sys_run = is_active || is_slp_hi || is_slp_med;
  wire logic is_lowpwr = !is_act_hi;

  // Medium-speed divider: tick every 8, 16, 32 or 64 clocks
  wire logic [1:0] med_shift = MED_SHIFT_MAX - med_sel;
  wire logic [MED_DIV_W-1:0] med_mask = MED_MASK_ALL >> med_shift;
  wire logic med_tick = is_medium && ((med_cnt & med_mask) == med_mask);

  // System clock base: undivided at high speed, divided at medium speed
  wire logic sys_base = (is_act_hi || is_slp_hi) || med_tick;

  // Subclock divided by four feeds the subclock prescaler
  wire logic sub_w4_tick = subclk_tick && (sub_div == SUB_DIV_LAST);

  // Prescaler hookup; neither count has a read path
  assign sys_bus.adv = sys_run && sys_base;
  assign sys_bus.clr = !sys_run;
  assign sub_bus.adv = sub_w4_tick;
  assign sub_bus.clr = sub_clr_req;

  ppm_counter u_sys_ps (
    .clk(clk),
    .rst_n(rst_n),
    .bus(sys_bus)
  );

  ppm_counter u_sub_ps (
    .clk(clk),
    .rst_n(rst_n),
    .bus(sub_bus)
  );

  // Divided tap strobes, one per count bit
  logic [SYS_PS_W-1:0] next_sys_taps;
  logic [SUB_PS_W-1:0] next_sub_taps;

  genvar gi;
  generate
    for (gi = 0; gi < SYS_PS_W; gi++) begin : g_sys_tap
      assign next_sys_taps[gi] = tap_fire(sys_bus.count, sys_bus.adv, gi);
    end
    for (gi = 0; gi < SUB_PS_W; gi++) begin : g_sub_tap
      assign next_sub_taps[gi] = tap_fire(
        {{(SYS_PS_W-SUB_PS_W){1'b0}}, sub_bus.count}, sub_bus.adv, gi);
    end
  endgenerate

  // Timekeeper source: subclock taps when the upper select bit is set
  wire logic [3:0] sys_tap_idx = SYS_TAP_BASE + {1'b0, tk_sel};
  wire logic sub_src_tick = (tk_sel <= SUB_TAP_LAST) ? next_sub_taps[tk_sel] : sub_w4_tick;
  wire logic sys_src_tick = next_sys_taps[sys_tap_idx];
  wire logic tk_src = cs3 ? sub_src_tick : sys_src_tick;
  // The timebase keeps going in watch, subactive and subsleep but holds in standby
  wire logic next_tk = tk_src && (mode != MODE_STBY);

  // Power-down entry and wake-up
  always_comb begin
    next_mode = mode;
    if (pd_instr && (is_active || is_subact)) begin
      next_mode = decode_target(mode, low_speed_on, medium_speed_on, software_standby, cs3, direct_transfer_on);
    end else if (irq_accepted) begin
      // Raw requests never wake the block; the accepted strobe does
      case (mode)
        MODE_SLP_HI, MODE_SLP_MED, MODE_STBY: begin
          next_mode = medium_speed_on ? MODE_ACT_MED : MODE_ACT_HI;
        end
        MODE_WATCH: begin
          if (low_speed_on) begin
            next_mode = MODE_SUBACT;
          end else begin
            next_mode = medium_speed_on ? MODE_ACT_MED : MODE_ACT_HI;
          end
        end
        MODE_SUBSLP: begin
          next_mode = MODE_SUBACT;
        end
        default: begin
          next_mode = mode;
        end
      endcase
    end
  end

  // Read mux; prescaler counts deliberately have no address
  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      REG_PCR1: next_rdata = pcr1;
      REG_PCR2: next_rdata = pcr2;
      REG_TKMR: next_rdata = tkmr;
      REG_STAT: next_rdata = mode;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pcr1 <= PCR1_RST;
      pcr2 <= PCR2_RST;
      tkmr <= TKMR_RST;
    end else begin
      if (wr_pcr1) begin
        pcr1 <= (reg_wdata & PCR1_WMASK) | PCR1_FIXED;
      end
      if (wr_pcr2) begin
        pcr2 <= reg_wdata & PCR2_WMASK;
      end
      if (wr_tkmr) begin
        tkmr <= reg_wdata & TKMR_WMASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= MODE_ACT_HI;
    end else begin
      mode <= next_mode;
    end
  end

  // The medium divider restarts whenever medium speed is left
  always_ff @(posedge clk) begin
    if (!rst_n || !is_medium) begin
      med_cnt <= '0;
    end else begin
      med_cnt <= med_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || sub_clr_req) begin
      sub_div <= '0;
    end else if (subclk_tick) begin
      sub_div <= sub_div + 1'b1;
    end
  end

  // Taps are registered, so every strobe rises on the same clock edge as its count bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sysclk_taps <= '0;
      subclk_taps <= '0;
      timekeeper_tick <= 1'b0;
    end else begin
      sysclk_taps <= next_sys_taps;
      subclk_taps <= next_sub_taps;
      timekeeper_tick <= next_tk;
    end
  end

  // Clock enables per mode
  assign sys_osc_run = sys_run;
  // Subactive runs the processor at the subclock rate
  assign cpu_clk_en = is_act_hi || (is_act_med && med_tick) || (is_subact && subclk_tick);
  assign periph_clk_en = sys_run && sys_base;
  // PWM only runs in the active modes; standby kills everything
  assign pwm_clk_en = is_active && sys_base && is_lowpwr == is_act_med;

endmodule : ppm_top

// ### ppm_top_props.sv
// Port-level assertions for the prescaler and power-mode block
`timescale 1ns/1ns
module ppm_top_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic subclk_tick,
  input wire logic pd_instr,
  input wire logic irq_accepted,
  input wire ppm_pkg::ppm_mode_t mode,
  input wire logic sys_osc_run,
  input wire logic cpu_clk_en,
  input wire logic periph_clk_en,
  input wire logic pwm_clk_en,
  input wire logic [ppm_pkg::SYS_PS_W-1:0] sysclk_taps
);
  import ppm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire lp = mode inside {MODE_SUBACT, MODE_SUBSLP, MODE_WATCH, MODE_STBY};
  wire slp = mode inside {MODE_SLP_HI, MODE_SLP_MED};
  wire halt = slp || mode inside {MODE_SUBSLP, MODE_WATCH, MODE_STBY};
  wire hi = mode == MODE_ACT_HI;
  // Three cycles of slack let the last strobe from before entry drain
  a_taps_lp_zero: assert property (lp [*3] |-> sysclk_taps == '0)
    else $error("system taps pulse in a low-power mode");
  a_osc_lp: assert property (sys_osc_run != lp)
    else $error("system oscillator state disagrees with mode");
  a_tap0_alt: assert property (hi && sysclk_taps[0] ##1 hi |-> !sysclk_taps[0])
    else $error("lowest tap pulses twice in a row");
  a_hi_full: assert property (hi |-> cpu_clk_en && periph_clk_en && pwm_clk_en)
    else $error("high-speed mode gates a clock");
  a_halt_cpu: assert property (halt |-> !cpu_clk_en)
    else $error("processor clock runs in a halted mode");
  a_sleep_pwm: assert property (slp |-> !pwm_clk_en)
    else $error("pwm clock runs in sleep");
  a_stby_off: assert property (mode == MODE_STBY |-> !periph_clk_en && !pwm_clk_en)
    else $error("peripheral clock runs in standby");
  a_sub_cpu: assert property (mode == MODE_SUBACT |-> cpu_clk_en == subclk_tick)
    else $error("subactive processor clock not from subclock");
  a_irq_hold: assert property (irq_accepted && !pd_instr && hi |=> hi)
    else $error("wake event changed a running mode");
  c_sleep: cover property (slp ##1 hi);
  c_stby: cover property (mode == MODE_STBY);
  c_subslp: cover property (mode == MODE_SUBSLP);
endmodule : ppm_top_props
bind ppm_top ppm_top_props i_props (.clk, .rst_n, .subclk_tick, .pd_instr, .irq_accepted,
  .mode, .sys_osc_run, .cpu_clk_en, .periph_clk_en, .pwm_clk_en, .sysclk_taps);

// ### ppm_top_tb.sv
// Self-checking bench for the prescaler and power-mode block
`timescale 1ns/1ns
module ppm_top_tb;
  import ppm_pkg::*;
  `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pd_instr = 0, irq_accepted = 0, clr = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, rd_d;
  logic [3:0] sel = '0;
  wire [DATA_W-1:0] reg_rdata;
  ppm_mode_t mode;
  wire [SYS_PS_W-1:0] sysclk_taps;
  wire [SUB_PS_W-1:0] subclk_taps;
  wire subclk_tick, timekeeper_tick, cpu_clk_en, periph_clk_en, pwm_clk_en, sys_osc_run;
  int n_sys, n_sub, n_tk, c, bad_count = 0, n_compared = 0;
  // Rows: event (1 pd, 0 wake), pcr1, pcr2, tkmr, expected mode
  localparam logic [35:0] ROWS [16] = '{
    36'h1_00_00_00_04, 36'h0_00_00_00_01, 36'h1_00_04_00_08, 36'h0_00_04_00_02,
    36'h1_80_00_00_80, 36'h0_80_00_00_01, 36'h1_80_00_08_40, 36'h0_80_00_08_01,
    36'h1_88_08_08_10, 36'h1_08_00_08_20, 36'h0_08_00_08_10, 36'h1_80_0C_08_02,
    36'h1_88_08_08_10, 36'h1_80_08_08_01, 36'h1_08_00_00_01, 36'h0_08_00_00_01};
  ppm_top i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .subclk_tick, .pd_instr, .irq_accepted, .mode, .sys_osc_run, .cpu_clk_en,
    .periph_clk_en, .pwm_clk_en, .sysclk_taps, .subclk_taps, .timekeeper_tick);
  ppm_periph_model i_per (.clk, .clr, .sys_sel(sel), .sysclk_taps, .subclk_taps,
    .timekeeper_tick, .subclk_tick, .n_sys, .n_sub, .n_tk);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic close_out;
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_d = reg_rdata;
    `CHK(rd_d, e)
  endtask : rc
  task automatic ev(input logic pd);
    @(posedge clk);
    pd_instr <= pd;
    irq_accepted <= !pd;
    @(posedge clk);
    pd_instr <= 1'b0;
    irq_accepted <= 1'b0;
  endtask : ev
  // Strobe counts over an exact multiple of the period do not depend on phase
  task automatic win(input logic [3:0] s, input int w);
    @(posedge clk);
    sel <= s;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (w) @(posedge clk);
    #1;
  endtask : win
  task automatic t_regs;
    rc(REG_PCR1, PCR1_RST);
    rc(REG_PCR2, PCR2_RST);
    rc(REG_STAT, 8'h01);
    wr(REG_PCR1, 8'h00);
    rc(REG_PCR1, 8'h04);
    wr(REG_STAT, 8'h55);
    rc(REG_STAT, 8'h01);
    wr(4'hF, 8'hFF);
    rc(4'hF, 8'h00);
    wr(REG_PCR1, PCR1_RST);
  endtask : t_regs
  task automatic t_sys;
    win(4'h0, 20);
    `CHK(n_sys, 10)
    win(4'h3, 160);
    `CHK(n_sys, 10)
    win(4'hC, 8192);
    `CHK(n_sys, 1)
    `CHK(n_tk, 128)
  endtask : t_sys
  task automatic t_med;
    wr(REG_PCR2, 8'h0C);
    ev(1'b1);
    rc(REG_STAT, 8'h02);
    for (int s = 0; s < 4; s++) begin
      wr(REG_PCR1, 8'(s));
      repeat (140) @(posedge clk);
      win(4'h0, 160 << s);
      `CHK(n_sys, 10)
    end
    wr(REG_PCR2, 8'h08);
    ev(1'b1);
    rc(REG_STAT, 8'h01);
  endtask : t_med
  task automatic t_modes;
    foreach (ROWS[i]) begin
      wr(REG_PCR1, ROWS[i][31:24]);
      wr(REG_PCR2, ROWS[i][23:16]);
      wr(REG_TKMR, ROWS[i][15:8]);
      ev(ROWS[i][32]);
      repeat (4) @(posedge clk);
      rc(REG_STAT, ROWS[i][7:0]);
      if (ROWS[i][7:0] >= 8'h10) `CHK(sysclk_taps, '0)
    end
  endtask : t_modes
  task automatic t_sub;
    wr(REG_TKMR, 8'h08);
    win(4'h0, 640);
    `CHK(n_sub, 10)
    `CHK(n_tk, 10)
    wr(REG_TKMR, 8'h0C);
    wr(REG_TKMR, 8'h08);
    c = 2;
    while (subclk_taps[0] !== 1'b1 && c < 80) begin
      @(posedge clk);
      #1 c++;
    end
    `CHK(c inside {[20:40]}, 1'b1)
  endtask : t_sub
  task automatic t_watch;
    wr(REG_PCR1, 8'h80);
    ev(1'b1);
    win(4'h0, 640);
    `CHK(n_sub, 10)
    `CHK(n_tk, 10)
    `CHK(n_sys, 0)
    `CHK(sys_osc_run, 1'b0)
    `CHK(cpu_clk_en, 1'b0)
    ev(1'b0);
    rc(REG_STAT, 8'h01);
  endtask : t_watch
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_sys();
    t_med();
    t_modes();
    t_sub();
    t_watch();
    close_out();
  end
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule : ppm_top_tb
